//--- auto_level_gain_control.sv
/*
 * Automatic level control of the input gain amplifiers with peak hold.
 * Assumes one hclk domain, samples on a one-cycle sample_valid strobe,
 * and an AHB-Lite master that holds clk_en high while it uses the bus.
 */
// Decided for this implementation: register access over AHB-Lite.
// ==========================================================
module auto_level_gain_control #(
	parameter int TIMER_W = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic power_down_pin,
	input wire logic sample_valid,
	input wire alc_pkg::sample_set_t samples,
	output alc_pkg::gain_pair_t applied_gain
);
	// ==========================================================
	// Parameter check
	if (TIMER_W < 12) begin : g_bad_timer
		$error("TIMER_W must be at least 12");
	end
	// ==========================================================
	// Functions
	function automatic logic [15:0] mag(input logic signed [15:0] s);
		mag = s[15] ? 16'(-s) : 16'(s);
	endfunction
	function automatic logic [7:0] peak_code(input logic [15:0] m);
		peak_code = m[15] ? 8'hff : m[14:7];
	endfunction
	function automatic logic [TIMER_W-1:0] period(input logic [11:0] base,
		input logic [1:0] sel);
		period = TIMER_W'(base) << sel;
	endfunction
	function automatic logic reg_hit(input logic [31:0] a,
		input logic [7:0] idx);
		reg_hit = (a[31:10] == 22'h000000) && (a[9:2] == idx);
	endfunction
	// ==========================================================
	// Power down pin synchroniser
	logic pdn_s1_q, pdn_s2_q, pdn_s3_q, pdn_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pdn_s1_q <= 1'b0;
			pdn_s2_q <= 1'b0;
			pdn_s3_q <= 1'b0;
			pdn_q <= 1'b0;
		end else if (clk_en) begin
			pdn_s1_q <= power_down_pin;
			pdn_s2_q <= pdn_s1_q;
			pdn_s3_q <= pdn_s2_q;
			if (pdn_s2_q == pdn_s3_q) begin
				pdn_q <= pdn_s3_q;
			end
		end
	end
	// ==========================================================
	// Registers and state
	logic [6:0] gain_reg_q, ceil_q, gl_q, gr_q, tgt_q;
	logic [5:0] opm_q;
	logic [3:0] pwr_q;
	logic [10:0] tim_q;
	logic [7:0] peak_q [2];
	logic wr_q, pl_q, pr_q, pend_lim_q, fast_q;
	logic [7:0] widx_q;
	logic [1:0] sgn_q;
	logic [TIMER_W-1:0] zc_cnt_q, lim_cnt_q, wt_cnt_q;
	alc_pkg::state_t state_q, state_d;
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	// ==========================================================
	// Bus decode
	wire take = hsel & htrans[1] & hready & clk_en;
	wire rd_take = take & !hwrite;
	wire [1:0] rd_peak;
	assign rd_peak[0] = rd_take & reg_hit(haddr, alc_pkg::IDX_PEAK_L);
	assign rd_peak[1] = rd_take & reg_hit(haddr, alc_pkg::IDX_PEAK_R);
	wire w_ceil = wr_q & (widx_q == alc_pkg::IDX_CEILING);
	wire w_opm = wr_q & (widx_q == alc_pkg::IDX_OPMODE);
	wire w_gain = wr_q & (widx_q == alc_pkg::IDX_GAIN);
	wire w_pwr = wr_q & (widx_q == alc_pkg::IDX_POWER);
	wire w_tim = wr_q & (widx_q == alc_pkg::IDX_TIMING);
	wire a_in = haddr[31:10] == 22'h000000;
	wire [7:0] a_idx = haddr[9:2];
	// ==========================================================
	// Level and crossing detection
	wire sv = sample_valid & clk_en;
	wire [15:0] m_l0 = mag(samples.left0);
	wire [15:0] m_r0 = mag(samples.right0);
	wire [15:0] m_l1 = mag(samples.left1);
	wire [15:0] m_r1 = mag(samples.right1);
	wire [15:0] lim_thr = tim_q[alc_pkg::TIM_THR] ? alc_pkg::LIM_THR1
		: alc_pkg::LIM_THR0;
	wire [15:0] rst_thr = tim_q[alc_pkg::TIM_THR] ? alc_pkg::RST_THR1
		: alc_pkg::RST_THR0;
	wire over = sv & ((m_l0 > lim_thr) | (m_r0 > lim_thr)
		| (m_l1 > lim_thr) | (m_r1 > lim_thr));
	wire above_rst = sv & ((m_l0 >= rst_thr) | (m_r0 >= rst_thr)
		| (m_l1 >= rst_thr) | (m_r1 >= rst_thr));
	wire zc_l = sv & (samples.left0[15] != sgn_q[0]);
	wire zc_r = sv & (samples.right0[15] != sgn_q[1]);
	// ==========================================================
	// Control decode
	wire pm_on = pwr_q[alc_pkg::POW_MODE +: 2] != 2'b00;
	wire pclr = !pdn_q | !pm_on;
	wire alc_on = opm_q[alc_pkg::OPM_ALC] & !pclr;
	wire zc_dis = opm_q[alc_pkg::OPM_ZC_DIS];
	wire impulse = !opm_q[alc_pkg::OPM_IMPULSE];
	wire zc_run = pl_q | pr_q;
	wire in_rec = state_q == alc_pkg::ST_RECOVER;
	wire [TIMER_W-1:0] zc_full = period(alc_pkg::ZC_BASE,
		tim_q[alc_pkg::TIM_ZC +: 2]);
	wire [TIMER_W-1:0] zc_lim = (fast_q & impulse & in_rec) ?
		zc_full >> 1 : zc_full;
	wire [TIMER_W-1:0] lim_lim = period(alc_pkg::LIM_BASE,
		tim_q[alc_pkg::TIM_LIM +: 2]);
	wire [TIMER_W-1:0] wt_lim = (fast_q & impulse & zc_dis) ? lim_lim
		: period(alc_pkg::WAIT_BASE, tim_q[alc_pkg::TIM_WAIT +: 2]);
	wire zc_to = zc_run & sv & (zc_cnt_q >= zc_lim);
	wire upd_l = pl_q & (zc_l | zc_to);
	wire upd_r = pr_q & (zc_r | zc_to);
	// ==========================================================
	// Gain arithmetic
	wire [6:0] gmin = (gl_q < gr_q) ? gl_q : gr_q;
	wire [6:0] lstep = {5'h00, tim_q[alc_pkg::TIM_LSTEP +: 2]} + 7'h01;
	wire [6:0] rstep = {5'h00, tim_q[alc_pkg::TIM_RSTEP +: 2]} + 7'h01;
	wire [6:0] dec_val = (gmin > lstep) ? gmin - lstep : 7'h00;
	wire [7:0] rsum = {1'b0, gmin} + {1'b0, rstep};
	wire [6:0] rec_val = (rsum > {1'b0, ceil_q}) ? ceil_q
		: rsum[6:0];
	wire lim_ready = zc_dis ? (lim_cnt_q == '0) : !(zc_run & pend_lim_q);
	wire do_lim = alc_on & over & lim_ready;
	wire wt_done = wt_cnt_q >= wt_lim;
	wire do_rec = alc_on & sv & !above_rst & wt_done & !zc_run
		& (gmin < ceil_q);
	wire alc_set = do_lim | do_rec;
	wire [6:0] alc_val = do_lim ? dec_val : rec_val;
	wire man_set = w_gain & !alc_on & !pclr;
	wire set_now = alc_set & zc_dis;
	wire set_pend = (alc_set & !zc_dis) | man_set;
	wire keep_pend = man_set & zc_run;
	wire zc_restart = set_pend & !zc_run;
	// ==========================================================
	// Bus slave registers
	wire stat = (state_q == alc_pkg::ST_MANUAL) & !zc_run;
	wire [31:0] rd_mux =
		!a_in ? 32'h00000000 :
		(a_idx == alc_pkg::IDX_CEILING) ? {25'h0000000, ceil_q} :
		(a_idx == alc_pkg::IDX_OPMODE) ? {26'h0000000, opm_q[5:4], stat,
			opm_q[2:0]} :
		(a_idx == alc_pkg::IDX_GAIN) ? {25'h0000000, gain_reg_q} :
		(a_idx == alc_pkg::IDX_PEAK_L) ? {24'h000000, peak_q[0]} :
		(a_idx == alc_pkg::IDX_PEAK_R) ? {24'h000000, peak_q[1]} :
		(a_idx == alc_pkg::IDX_POWER) ? {28'h0000000, pwr_q} :
		(a_idx == alc_pkg::IDX_TIMING) ? {21'h000000, tim_q} :
		(a_idx == alc_pkg::IDX_APPLIED) ? {13'h0000, state_q, 1'b0, gr_q,
			1'b0, gl_q} : 32'h00000000;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			widx_q <= 8'h00;
			hrdata_q <= 32'h00000000;
			hreadyout_q <= 1'b1;
		end else if (clk_en) begin
			wr_q <= take & hwrite & a_in;
			widx_q <= a_idx;
			if (rd_take) begin
				hrdata_q <= rd_mux;
			end
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gain_reg_q <= alc_pkg::GAIN_RST;
			ceil_q <= alc_pkg::CEIL_RST;
			opm_q <= alc_pkg::OPM_RST;
			pwr_q <= alc_pkg::POW_RST;
			tim_q <= alc_pkg::TIM_RST;
		end else if (clk_en) begin
			if (w_gain) begin
				gain_reg_q <= hwdata[6:0];
			end
			if (w_ceil) begin
				ceil_q <= hwdata[6:0];
			end
			if (w_opm) begin
				opm_q <= hwdata[5:0];
			end
			if (w_pwr) begin
				pwr_q <= hwdata[3:0];
			end
			if (w_tim) begin
				tim_q <= hwdata[10:0];
			end
		end
	end
	// ==========================================================
	// Peak hold
	wire pk_clr = !pdn_q | (!pwr_q[alc_pkg::POW_A] & !pwr_q[alc_pkg::POW_B]);
	wire [7:0] pk_in [2];
	assign pk_in[0] = peak_code(m_l0);
	assign pk_in[1] = peak_code(m_r0);
	for (genvar c = 0; c < 2; c++) begin : g_peak
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				peak_q[c] <= alc_pkg::PEAK_RST;
			end else if (clk_en) begin
				if (pk_clr) begin
					peak_q[c] <= alc_pkg::PEAK_RST;
				end else if (rd_peak[c]) begin
					peak_q[c] <= sv ? pk_in[c] : alc_pkg::PEAK_RST;
				end else if (sv && pk_in[c] > peak_q[c]) begin
					peak_q[c] <= pk_in[c];
				end
			end
		end
	end
	// ==========================================================
	// Level control state
	always_comb begin
		state_d = state_q;
		case (state_q)
			alc_pkg::ST_MANUAL, alc_pkg::ST_RECOVER: begin
				if (alc_on) begin
					state_d = alc_pkg::ST_RECOVER;
				end
			end
			alc_pkg::ST_LIMIT: begin
				if (sv && !over && lim_ready) begin
					state_d = alc_pkg::ST_RECOVER;
				end
			end
			default: begin
				state_d = alc_pkg::ST_MANUAL;
			end
		endcase
		if (do_lim) begin
			state_d = alc_pkg::ST_LIMIT;
		end
		if (!alc_on) begin
			state_d = alc_pkg::ST_MANUAL;
		end
	end
	// ==========================================================
	// Applied gains and pending updates
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gl_q <= alc_pkg::GAIN_RST;
			gr_q <= alc_pkg::GAIN_RST;
			tgt_q <= alc_pkg::GAIN_RST;
			pl_q <= 1'b0;
			pr_q <= 1'b0;
			pend_lim_q <= 1'b0;
			state_q <= alc_pkg::ST_MANUAL;
		end else if (clk_en) begin
			state_q <= state_d;
			if (pclr) begin
				gl_q <= alc_pkg::GAIN_RST;
				gr_q <= alc_pkg::GAIN_RST;
				pl_q <= 1'b0;
				pr_q <= 1'b0;
			end else if (set_now) begin
				gl_q <= alc_val;
				gr_q <= alc_val;
				pl_q <= 1'b0;
				pr_q <= 1'b0;
			end else if (set_pend) begin
				tgt_q <= man_set ? hwdata[6:0] : alc_val;
				pend_lim_q <= do_lim;
				pl_q <= keep_pend ? pl_q & !upd_l : 1'b1;
				pr_q <= keep_pend ? pr_q & !upd_r : 1'b1;
				if (keep_pend && upd_l) begin
					gl_q <= tgt_q;
				end
				if (keep_pend && upd_r) begin
					gr_q <= tgt_q;
				end
			end else begin
				if (upd_l) begin
					gl_q <= tgt_q;
					pl_q <= 1'b0;
				end
				if (upd_r) begin
					gr_q <= tgt_q;
					pr_q <= 1'b0;
				end
			end
		end
	end
	// ==========================================================
	// Timers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			zc_cnt_q <= '0;
			lim_cnt_q <= '0;
			wt_cnt_q <= '0;
			fast_q <= 1'b0;
			sgn_q <= 2'b00;
		end else if (clk_en) begin
			if (sv) begin
				sgn_q <= {samples.right0[15], samples.left0[15]};
			end
			if (pclr || zc_restart) begin
				zc_cnt_q <= '0;
			end else if (zc_run && sv) begin
				zc_cnt_q <= zc_cnt_q + 1'b1;
			end
			if (do_lim) begin
				lim_cnt_q <= lim_lim;
			end else if (sv && lim_cnt_q != '0) begin
				lim_cnt_q <= lim_cnt_q - 1'b1;
			end
			if (!alc_on || above_rst || alc_set) begin
				wt_cnt_q <= '0;
			end else if (sv && !wt_done) begin
				wt_cnt_q <= wt_cnt_q + 1'b1;
			end
			if (!alc_on || (do_rec && rec_val == ceil_q)) begin
				fast_q <= 1'b0;
			end else if (do_lim && impulse) begin
				fast_q <= 1'b1;
			end
		end
	end
	// ==========================================================
	// Outputs
	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = 1'b0 & hreadyout_q;
	assign applied_gain = '{left: gl_q, right: gr_q};
endmodule // auto_level_gain_control

//--- alc_pkg.sv
/*
 * Shared constants and types for the automatic level gain control block.
 * Assumes a 32-bit AHB-Lite register bus and 16-bit two's complement samples.
 */
package alc_pkg;
	// ==========================================================
	// Widths
	localparam int SAMPLE_W = 16;
	localparam int GAIN_W = 7;
	// ==========================================================
	// Register indices, byte address is four times the index
	localparam logic [7:0] IDX_CEILING = 8'h05;
	localparam logic [7:0] IDX_OPMODE = 8'h06;
	localparam logic [7:0] IDX_GAIN = 8'h07;
	localparam logic [7:0] IDX_PEAK_L = 8'h08;
	localparam logic [7:0] IDX_PEAK_R = 8'h09;
	localparam logic [7:0] IDX_POWER = 8'h0a;
	localparam logic [7:0] IDX_TIMING = 8'h0b;
	localparam logic [7:0] IDX_APPLIED = 8'h0c;
	// ==========================================================
	// Field positions
	localparam int OPM_ALC = 0;
	localparam int OPM_FADE_OUT_ENABLE = 1;
	localparam int OPM_FADE_IN_ENABLE = 2;
	localparam int OPM_STAT = 3;
	localparam int OPM_IMPULSE = 4;
	localparam int OPM_ZC_DIS = 5;
	localparam int POW_MODE = 0;
	localparam int POW_A = 2;
	localparam int POW_B = 3;
	localparam int TIM_ZC = 0;
	localparam int TIM_LIM = 2;
	localparam int TIM_WAIT = 4;
	localparam int TIM_LSTEP = 6;
	localparam int TIM_THR = 8;
	localparam int TIM_RSTEP = 9;
	// ==========================================================
	// Values after reset
	localparam logic [6:0] GAIN_RST = 7'h28;
	localparam logic [6:0] CEIL_RST = 7'h28;
	localparam logic [5:0] OPM_RST = 6'h00;
	localparam logic [3:0] POW_RST = 4'h0;
	localparam logic [10:0] TIM_RST = 11'h000;
	localparam logic [7:0] PEAK_RST = 8'h00;
	// ==========================================================
	// Level thresholds as sample magnitudes
	localparam logic [15:0] LIM_THR0 = 16'h4027;
	localparam logic [15:0] LIM_THR1 = 16'h50c3;
	localparam logic [15:0] RST_THR0 = 16'h32f5;
	localparam logic [15:0] RST_THR1 = 16'h4027;
	// ==========================================================
	// Period bases in samples, doubled per select step
	localparam logic [11:0] ZC_BASE = 12'h080;
	localparam logic [11:0] LIM_BASE = 12'h010;
	localparam logic [11:0] WAIT_BASE = 12'h080;
	// ==========================================================
	// Types
	typedef struct packed {
		logic signed [15:0] left0;
		logic signed [15:0] right0;
		logic signed [15:0] left1;
		logic signed [15:0] right1;
	} sample_set_t;
	typedef struct packed {
		logic [6:0] left;
		logic [6:0] right;
	} gain_pair_t;
	typedef enum logic [2:0] {
		ST_MANUAL = 3'b001,
		ST_LIMIT = 3'b010,
		ST_RECOVER = 3'b100
	} state_t;
endpackage

//--- alc_props.sv
/*
 * Checker for the level control block: bus answers, gain and peak relations.
 * Assumes it is bound to auto_level_gain_control and sees its ports only.
 */
module alc_props (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic power_down_pin,
	input wire logic sample_valid,
	input wire alc_pkg::gain_pair_t applied_gain
);
	// ====================
	// Helper logic tracks writes and peak reads.
	logic tk;
	logic rd_l;
	logic wgain_q;
	logic wpow_q;
	logic clr_l_q;
	logic [6:0] gw_q;
	logic [13:0] dflt;
	assign tk = hsel & htrans[1] & hready & clk_en;
	assign rd_l = tk & !hwrite & (haddr == 32'h20);
	assign dflt = {alc_pkg::GAIN_RST, alc_pkg::GAIN_RST};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wgain_q <= 1'b0;
			wpow_q <= 1'b0;
			clr_l_q <= 1'b0;
			gw_q <= alc_pkg::GAIN_RST;
		end else if (clk_en) begin
			wgain_q <= tk & hwrite & (haddr == 32'h1c);
			wpow_q <= tk & hwrite & (haddr == 32'h28);
			clr_l_q <= (sample_valid & clk_en) ? 1'b0 : (rd_l | clr_l_q);
			if (wgain_q) begin
				gw_q <= hwdata[6:0];
			end
		end
	end
	// ====================
	// Assertions.
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	a_ready_high: assert property (hreadyout == 1'b1)
		else $error("hreadyout low");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("hresp not okay");
	a_gain_readback:
	assert property (tk && !hwrite && haddr == 32'h1c |=> hrdata[6:0] == gw_q)
		else $error("gain readback differs from last write");
	a_gain_cause:
	assert property ($changed(applied_gain) && !$past(sample_valid)
		&& !$past(sample_valid, 2) |-> applied_gain == dflt)
		else $error("gain moved without a sample");
	a_gain_range:
	assert property (applied_gain.left <= 7'h60
		&& applied_gain.right <= 7'h60)
		else $error("gain code above range");
	a_power_default:
	assert property (wpow_q && hwdata[1:0] == 2'b00
		|-> ##[1:2] applied_gain == dflt)
		else $error("gain not default in power mode zero");
	a_peak_clear:
	assert property (rd_l && clr_l_q |=> hrdata[7:0] == 8'h00)
		else $error("peak not cleared by read");
	a_peak_off:
	assert property (!power_down_pin [*6] ##0 rd_l |=> hrdata[7:0] == 8'h00)
		else $error("peak not cleared while powered down");
endmodule // alc_props

//--- test_auto_level_gain_control.sv
/*
 * Self-checking bench for auto_level_gain_control over AHB-Lite.
 * Assumes alc_pkg and the checker alc_props are compiled before it.
 */
`define CHECK(got, exp) begin \
	comparisons++; \
	if ((got) !== (exp)) begin \
		err_count++; \
		$display("ERROR %0t: got %h expected %h", $time, got, exp); \
	end \
end
module test_auto_level_gain_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic power_down_pin = 1'b1;
	logic sample_valid = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	alc_pkg::sample_set_t samples = '0;
	logic [31:0] hrdata;
	logic hreadyout, hresp;
	alc_pkg::gain_pair_t applied_gain;
	logic [6:0] g;
	int err_count = 0;
	int comparisons = 0;
	auto_level_gain_control #(.TIMER_W(16)) auto_level_gain_control_i (
		.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp),
		.power_down_pin(power_down_pin), .sample_valid(sample_valid),
		.samples(samples), .applied_gain(applied_gain)
	);
	always #5 hclk = ~hclk;
	// ====================
	// Bus, sample and compare tasks.
	task automatic bus(input logic w, input logic [31:0] a, d,
		output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdchk(input logic [31:0] a, e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		`CHECK(q, e)
	endtask
	task automatic smp(input logic [15:0] l, r, input int n);
		repeat (n) begin
			samples <= {l, r, l, r};
			sample_valid <= 1'b1;
			@(posedge hclk);
			sample_valid <= 1'b0;
			@(posedge hclk);
		end
	endtask
	task automatic gchk(input logic [6:0] l, r);
		@(negedge hclk);
		`CHECK(applied_gain, {l, r})
		@(posedge hclk);
	endtask
	// ====================
	// Scenarios.
	task automatic t_reset;
		gchk(7'h28, 7'h28);
		rdchk(32'h1c, 32'h28);
		rdchk(32'h20, 32'h0);
		rdchk(32'h24, 32'h0);
		rdchk(32'h14, 32'h28);
		rdchk(32'h3c, 32'h0);
		wr(32'h28, 32'hd);
	endtask
	task automatic t_manual;
		wr(32'h1c, 32'h30);
		rdchk(32'h1c, 32'h30);
		smp(16'h0100, 16'h0100, 4);
		gchk(7'h28, 7'h28);
		smp(16'hff00, 16'h0100, 1);
		gchk(7'h30, 7'h28);
		smp(16'hff00, 16'hff00, 1);
		gchk(7'h30, 7'h30);
		wr(32'h1c, 32'h20);
		smp(16'h0100, 16'hff00, 1);
		gchk(7'h20, 7'h30);
		wr(32'h1c, 32'h18);
		smp(16'h0100, 16'hff00, 130);
		gchk(7'h20, 7'h18);
		wr(32'h1c, 32'h28);
		smp(16'hff00, 16'h0100, 1);
		gchk(7'h28, 7'h28);
	endtask
	task automatic t_peak;
		smp(16'h4000, 16'hf000, 1);
		smp(16'h0100, 16'h0100, 1);
		rdchk(32'h20, 32'h80);
		rdchk(32'h24, 32'h20);
		rdchk(32'h20, 32'h0);
		smp(16'h8000, 16'h7fff, 1);
		rdchk(32'h20, 32'hff);
		rdchk(32'h24, 32'hff);
		rdchk(32'h24, 32'h0);
		smp(16'h4000, 16'h4000, 1);
		power_down_pin <= 1'b0;
		repeat (8) @(posedge hclk);
		rdchk(32'h20, 32'h0);
		power_down_pin <= 1'b1;
		repeat (8) @(posedge hclk);
	endtask
	task automatic t_alc;
		wr(32'h2c, 32'h600);
		wr(32'h18, 32'h31);
		smp(16'h5000, 16'h5000, 40);
		@(negedge hclk);
		g = applied_gain.left;
		`CHECK(g, 7'h25)
		`CHECK(applied_gain.right, g)
		@(posedge hclk);
		smp(16'h3800, 16'h3800, 300);
		gchk(g, g);
		wr(32'h1c, 32'h10);
		rdchk(32'h1c, 32'h10);
		gchk(g, g);
		smp(16'h0100, 16'h0100, 600);
		gchk(7'h28, 7'h28);
		rdchk(32'h1c, 32'h10);
		wr(32'h18, 32'h0);
	endtask
	task automatic t_power;
		wr(32'h1c, 32'h30);
		smp(16'hff00, 16'hff00, 1);
		gchk(7'h30, 7'h30);
		wr(32'h28, 32'hc);
		repeat (2) @(posedge hclk);
		gchk(7'h28, 7'h28);
		smp(16'h4000, 16'h4000, 1);
		wr(32'h28, 32'h1);
		repeat (2) @(posedge hclk);
		rdchk(32'h20, 32'h0);
	endtask
	task automatic t_limzc;
		wr(32'h18, 32'h1);
		smp(16'h5000, 16'h5000, 1);
		gchk(7'h28, 7'h28);
		smp(16'hb000, 16'h5000, 1);
		gchk(7'h27, 7'h28);
		smp(16'hb000, 16'hb000, 1);
		gchk(7'h27, 7'h27);
		rdchk(32'h30, 32'h00022727);
		smp(16'hb000, 16'hb000, 120);
		gchk(7'h27, 7'h27);
		smp(16'hb000, 16'hb000, 20);
		gchk(7'h26, 7'h26);
		wr(32'h18, 32'h0);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (6) @(posedge hclk);
		t_reset();
		t_manual();
		t_peak();
		t_alc();
		t_power();
		t_limzc();
		tally_and_finish();
	end
	initial begin
		#500us;
		err_count++;
		tally_and_finish();
	end
endmodule // test_auto_level_gain_control
bind auto_level_gain_control alc_props alc_props_i (
	.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.power_down_pin(power_down_pin), .sample_valid(sample_valid),
	.applied_gain(applied_gain)
);
